/* File: pin_share_pkg.sv */
// Package of constants and types for the configuration and serial pin sharing logic.
package pin_share_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // Configuration clock cycles after done rises before user pins go live.
  localparam int DONE_IO_CYCLES = 49;
  localparam int DONE_CNT_W = 6;

  // ----------------------------------------------------------------
  // Pin indices inside one SPI port
  // ----------------------------------------------------------------
  localparam int SPI_PINS = 4;
  localparam int PIN_SCK = 0;
  localparam int PIN_MISO = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_CS = 3;

  // I2C pin indices.
  localparam int I2C_PINS = 2;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;

  // Idle level of the active-low chip select.
  localparam logic CS_IDLE = 1'b1;

  // Phases of the device life cycle.
  typedef enum logic [1:0] {
    PH_CONFIG,
    PH_WAIT_IO,
    PH_USER
  } phase_t;

endpackage : pin_share_pkg

/* File: spi_pin_mux.sv */
// One SPI port's pin steering between serial function, configuration and general I/O.
`timescale 1ns/1ps
module spi_pin_mux
  import pin_share_pkg::*;
(
  // Mode
  input wire logic cfg_active,
  input wire logic user_active,
  input wire logic is_master,
  input wire logic [SPI_PINS-1:0] use_serial,
  // Configuration engine drive
  input wire logic cfg_sck,
  input wire logic cfg_mosi,
  input wire logic cfg_cs_n,
  // Serial controller drive
  input wire logic ser_sck,
  input wire logic ser_miso,
  input wire logic ser_mosi,
  input wire logic ser_cs_n,
  // General I/O drive
  input wire logic [SPI_PINS-1:0] gpio_out,
  input wire logic [SPI_PINS-1:0] gpio_oe,
  // Pin level requested
  output logic [SPI_PINS-1:0] pin_out,
  output logic [SPI_PINS-1:0] pin_oe
);

  // ----------------------------------------------------------------
  // Steering
  // ----------------------------------------------------------------
  // Configuration wins; pins float outside configuration and user mode.
  always_comb begin
    pin_out = '0;
    pin_oe = '0;
    if (cfg_active) begin
      pin_out[PIN_SCK] = cfg_sck;
      pin_oe[PIN_SCK] = 1'b1;
      pin_oe[PIN_MISO] = 1'b0;
      pin_out[PIN_MOSI] = cfg_mosi;
      pin_oe[PIN_MOSI] = 1'b1;
      pin_out[PIN_CS] = cfg_cs_n;
      pin_oe[PIN_CS] = 1'b1;
    end else if (user_active) begin
      for (int i = 0; i < SPI_PINS; i++) begin
        if (!use_serial[i]) begin
          pin_out[i] = gpio_out[i];
          pin_oe[i] = gpio_oe[i];
        end
      end
      if (use_serial[PIN_SCK]) begin
        pin_out[PIN_SCK] = ser_sck;
        pin_oe[PIN_SCK] = is_master;
      end
      if (use_serial[PIN_MISO]) begin
        pin_out[PIN_MISO] = ser_miso;
        pin_oe[PIN_MISO] = !is_master;
      end
      if (use_serial[PIN_MOSI]) begin
        pin_out[PIN_MOSI] = ser_mosi;
        pin_oe[PIN_MOSI] = is_master;
      end
      if (use_serial[PIN_CS]) begin
        pin_out[PIN_CS] = ser_cs_n;
        pin_oe[PIN_CS] = is_master;
      end
    end
  end

endmodule : spi_pin_mux

/* File: config_pin_share.sv */
// Top of the pin sharing logic for configuration, two SPI ports and one I2C port.
// Operation
// - Active-low config reset restarts configuration.
// - Done pin, weakly high, shows configuration complete.
// - Configuring: drive port A clock to memory.
// - Configuring: port A master-in is input.
// - Configuring: port A master-out drives memory.
// - Configuring: port A chip select drives memory.
// - User: master-in input as master, output slave.
// - User: master-out output as master, input slave.
// - User: chip select output master, input slave.
// - Unused SPI pins become user general I/O.
// - I2C uses one clock and one data pin.
// - Unused I2C pins become user general I/O.
// - Wait 49 cycles after done before I/O.
`timescale 1ns/1ps
module config_pin_share
  import pin_share_pkg::*;
#(
  parameter int WAIT_CYCLES = DONE_IO_CYCLES
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Configuration reset pin
  input wire logic config_reset_n,
  // Configuration done pin
  input wire logic config_done_in,
  output logic config_done_out,
  output logic config_done_oe,
  // Configuration engine
  input wire logic cfg_load_done,
  input wire logic cfg_sck,
  input wire logic cfg_mosi,
  input wire logic cfg_cs_n,
  output logic cfg_miso,
  output logic cfg_running,
  // Loaded pin selection
  input wire logic spi_a_master,
  input wire logic spi_b_master,
  input wire logic [SPI_PINS-1:0] spi_a_use,
  input wire logic [SPI_PINS-1:0] spi_b_use,
  input wire logic i2c_a_use,
  // SPI controllers
  input wire logic spi_a_sck_o,
  input wire logic spi_a_miso_o,
  input wire logic spi_a_mosi_o,
  input wire logic spi_a_cs_n_o,
  input wire logic spi_b_sck_o,
  input wire logic spi_b_miso_o,
  input wire logic spi_b_mosi_o,
  input wire logic spi_b_cs_n_o,
  output logic [SPI_PINS-1:0] spi_a_pin_level,
  output logic [SPI_PINS-1:0] spi_b_pin_level,
  // I2C controller, open drain pull-low requests
  input wire logic i2c_scl_low,
  input wire logic i2c_sda_low,
  output logic [I2C_PINS-1:0] i2c_pin_level,
  // User general I/O
  input wire logic [SPI_PINS-1:0] gpio_a_out,
  input wire logic [SPI_PINS-1:0] gpio_a_oe,
  input wire logic [SPI_PINS-1:0] gpio_b_out,
  input wire logic [SPI_PINS-1:0] gpio_b_oe,
  input wire logic [I2C_PINS-1:0] gpio_i2c_out,
  input wire logic [I2C_PINS-1:0] gpio_i2c_oe,
  output logic user_io_live,
  // SPI port A pins
  input wire logic [SPI_PINS-1:0] spi_port_a_in,
  output logic [SPI_PINS-1:0] spi_port_a_out,
  output logic [SPI_PINS-1:0] spi_port_a_oe,
  // SPI port B pins
  input wire logic [SPI_PINS-1:0] spi_port_b_in,
  output logic [SPI_PINS-1:0] spi_port_b_out,
  output logic [SPI_PINS-1:0] spi_port_b_oe,
  // I2C port A pins
  input wire logic [I2C_PINS-1:0] i2c_port_a_in,
  output logic [I2C_PINS-1:0] i2c_port_a_out,
  output logic [I2C_PINS-1:0] i2c_port_a_oe
);

  // ----------------------------------------------------------------
  // Phase control
  // ----------------------------------------------------------------
  phase_t phase_r;
  logic [DONE_CNT_W-1:0] wait_cnt_r;
  logic spi_a_master_r;
  logic spi_b_master_r;
  logic [SPI_PINS-1:0] spi_a_use_r;
  logic [SPI_PINS-1:0] spi_b_use_r;
  logic i2c_a_use_r;

  localparam logic [DONE_CNT_W-1:0] WAIT_LAST = DONE_CNT_W'(WAIT_CYCLES - 1);

  // A low reset pin throws the device back into configuration at any phase.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      phase_r <= PH_CONFIG;
    end else if (!config_reset_n) begin
      phase_r <= PH_CONFIG;
    end else begin
      case (phase_r)
        PH_CONFIG: if (cfg_load_done) phase_r <= PH_WAIT_IO;
        PH_WAIT_IO: if (wait_cnt_r == WAIT_LAST) phase_r <= PH_USER;
        PH_USER: phase_r <= PH_USER;
        default: phase_r <= PH_CONFIG;
      endcase
    end
  end

  // Counts configuration clocks after done rises; held at zero otherwise.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wait_cnt_r <= '0;
    end else if (phase_r == PH_WAIT_IO && config_reset_n) begin
      wait_cnt_r <= wait_cnt_r + 1'b1;
    end else begin
      wait_cnt_r <= '0;
    end
  end

  // Selection is captured once at the end of loading, so live inputs cannot
  // change a pin's role during user mode.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      spi_a_master_r <= 1'b0;
      spi_b_master_r <= 1'b0;
      spi_a_use_r <= '0;
      spi_b_use_r <= '0;
      i2c_a_use_r <= 1'b0;
    end else if (phase_r == PH_CONFIG && cfg_load_done && config_reset_n) begin
      spi_a_master_r <= spi_a_master;
      spi_b_master_r <= spi_b_master;
      spi_a_use_r <= spi_a_use;
      spi_b_use_r <= spi_b_use;
      i2c_a_use_r <= i2c_a_use;
    end
  end

  // ----------------------------------------------------------------
  // SPI steering
  // ----------------------------------------------------------------
  logic cfg_phase;
  logic user_phase;
  logic [SPI_PINS-1:0] a_out;
  logic [SPI_PINS-1:0] a_oe;
  logic [SPI_PINS-1:0] b_out;
  logic [SPI_PINS-1:0] b_oe;

  assign cfg_phase = (phase_r == PH_CONFIG);
  assign user_phase = (phase_r == PH_USER);

  spi_pin_mux u_mux_a (
    .cfg_active(cfg_phase),
    .user_active(user_phase),
    .is_master(spi_a_master_r),
    .use_serial(spi_a_use_r),
    .cfg_sck(cfg_sck),
    .cfg_mosi(cfg_mosi),
    .cfg_cs_n(cfg_cs_n),
    .ser_sck(spi_a_sck_o),
    .ser_miso(spi_a_miso_o),
    .ser_mosi(spi_a_mosi_o),
    .ser_cs_n(spi_a_cs_n_o),
    .gpio_out(gpio_a_out),
    .gpio_oe(gpio_a_oe),
    .pin_out(a_out),
    .pin_oe(a_oe)
  );

  // Port B has no configuration role, so its configuration drive is held off.
  spi_pin_mux u_mux_b (
    .cfg_active(1'b0),
    .user_active(user_phase),
    .is_master(spi_b_master_r),
    .use_serial(spi_b_use_r),
    .cfg_sck(1'b0),
    .cfg_mosi(1'b0),
    .cfg_cs_n(CS_IDLE),
    .ser_sck(spi_b_sck_o),
    .ser_miso(spi_b_miso_o),
    .ser_mosi(spi_b_mosi_o),
    .ser_cs_n(spi_b_cs_n_o),
    .gpio_out(gpio_b_out),
    .gpio_oe(gpio_b_oe),
    .pin_out(b_out),
    .pin_oe(b_oe)
  );

  // ----------------------------------------------------------------
  // Registered pin drive
  // ----------------------------------------------------------------
  // All outputs are registered; this adds one cycle of pin latency but keeps
  // glitches from the steering logic off the pads.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      spi_port_a_out <= '0;
      spi_port_a_oe <= '0;
      spi_port_b_out <= '0;
      spi_port_b_oe <= '0;
    end else begin
      spi_port_a_out <= a_out;
      spi_port_a_oe <= a_oe;
      spi_port_b_out <= b_out;
      spi_port_b_oe <= b_oe;
    end
  end

  // In I2C mode the pins are open drain: the controller only ever pulls low.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      i2c_port_a_out <= '0;
      i2c_port_a_oe <= '0;
    end else if (user_phase && i2c_a_use_r) begin
      i2c_port_a_out <= '0;
      i2c_port_a_oe[PIN_SCL] <= i2c_scl_low;
      i2c_port_a_oe[PIN_SDA] <= i2c_sda_low;
    end else if (user_phase) begin
      i2c_port_a_out <= gpio_i2c_out;
      i2c_port_a_oe <= gpio_i2c_oe;
    end else begin
      i2c_port_a_out <= '0;
      i2c_port_a_oe <= '0;
    end
  end

  // The done pin is held low while configuring and released afterwards,
  // so the weak pull-up or another device on the wire sets its level.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      config_done_out <= 1'b0;
      config_done_oe <= 1'b1;
    end else begin
      config_done_out <= 1'b0;
      config_done_oe <= cfg_phase;
    end
  end

  // ----------------------------------------------------------------
  // Returned levels and status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfg_miso <= 1'b0;
      cfg_running <= 1'b1;
      user_io_live <= 1'b0;
      spi_a_pin_level <= '0;
      spi_b_pin_level <= '0;
      i2c_pin_level <= '0;
    end else begin
      cfg_miso <= cfg_phase & spi_port_a_in[PIN_MISO];
      cfg_running <= cfg_phase;
      user_io_live <= user_phase && config_done_in;
      spi_a_pin_level <= spi_port_a_in;
      spi_b_pin_level <= spi_port_b_in;
      i2c_pin_level <= i2c_port_a_in;
    end
  end

endmodule : config_pin_share

/* File: config_pin_share_asserts.sv */
// Port-level checks for the pin sharing top, bound into it.
`timescale 1ns/1ps
module config_pin_share_asserts
  import pin_share_pkg::*;
#(
  parameter int WAIT_CYCLES = DONE_IO_CYCLES
)(
  // Clock, reset and phase
  input wire logic clk_sys, reset, config_reset_n, cfg_load_done, cfg_running, user_io_live,
  // Done pin, configuration drive, selection and requests
  input wire logic config_done_in, config_done_out, config_done_oe, cfg_sck,
  input wire logic spi_a_master, spi_b_master, i2c_a_use, i2c_scl_low, i2c_sda_low,
  input wire logic [SPI_PINS-1:0] spi_a_use, spi_b_use, gpio_a_oe, gpio_b_oe,
  input wire logic [I2C_PINS-1:0] gpio_i2c_oe, i2c_port_a_oe,
  // Pins
  input wire logic [SPI_PINS-1:0] spi_port_a_out, spi_port_a_oe, spi_port_b_oe
);
  logic ma_r, mb_r, iu_r, cfg_prev_r, live_prev_r;
  logic [SPI_PINS-1:0] ua_r, ub_r;
  logic [7:0] cnt_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Selection copied at the load edge only; later changes must not reach the pins.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {ma_r, mb_r, iu_r, ua_r, ub_r} <= '0;
    end else if (cfg_running && cfg_load_done && config_reset_n) begin
      {ma_r, mb_r, iu_r} <= {spi_a_master, spi_b_master, i2c_a_use};
      {ua_r, ub_r} <= {spi_a_use, spi_b_use};
    end
  end
  // Phase history cleared by reset, so the first edge after release is not judged.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {cfg_prev_r, live_prev_r} <= '0;
    end else begin
      {cfg_prev_r, live_prev_r} <= {cfg_running, user_io_live};
    end
  end
  // Cycles spent out of configuration, saturating.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (cfg_running) begin
      cnt_r <= '0;
    end else if (cnt_r != 8'hff) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  function automatic logic [SPI_PINS-1:0] steer(input logic m,
    input logic [SPI_PINS-1:0] u, input logic [SPI_PINS-1:0] g);
    return ({m, m, !m, m} & u) | (g & ~u);
  endfunction : steer
  a_restart_cfg: assert property (!config_reset_n |-> ##2 cfg_running)
    else $error("config reset did not restart");
  a_done_low: assert property (cfg_running && cfg_prev_r |-> config_done_oe && !config_done_out)
    else $error("done pin not low in config");
  a_cfg_port_a: assert property (cfg_running && cfg_prev_r |->
    spi_port_a_oe == 4'hd && spi_port_a_out[PIN_SCK] == $past(cfg_sck)) else $error("port a config");
  a_cfg_quiet: assert property (cfg_running && cfg_prev_r |->
    spi_port_b_oe == '0 && i2c_port_a_oe == '0) else $error("pins driven in config");
  a_wait_floor: assert property (user_io_live |-> cnt_r >= WAIT_CYCLES)
    else $error("user pins live too early");
  a_wait_ceil: assert property (cnt_r == WAIT_CYCLES + 1 && config_done_in && config_reset_n
    && $past(config_reset_n) |-> user_io_live) else $error("user pins live too late");
  a_steer_a: assert property (user_io_live && live_prev_r |->
    spi_port_a_oe == steer(ma_r, ua_r, $past(gpio_a_oe))) else $error("port a steering");
  a_steer_b: assert property (user_io_live && live_prev_r |->
    spi_port_b_oe == steer(mb_r, ub_r, $past(gpio_b_oe))) else $error("port b steering");
  a_i2c_steer: assert property (user_io_live && live_prev_r |-> i2c_port_a_oe ==
    (iu_r ? {$past(i2c_sda_low), $past(i2c_scl_low)} : $past(gpio_i2c_oe))) else $error("i2c");
  c_load: cover property (cfg_running && cfg_load_done && config_reset_n);
  c_live_master: cover property (user_io_live && ma_r);
  c_restart: cover property (user_io_live ##1 !config_reset_n);
endmodule : config_pin_share_asserts
bind config_pin_share config_pin_share_asserts #(.WAIT_CYCLES(WAIT_CYCLES)) u_chk (.*);

/* File: far_pins.sv */
// Far side of the shared pins: configuration memory, toggling levels on undriven SPI lines and I2C pull-ups.
`timescale 1ns/1ps
module far_pins
  import pin_share_pkg::*;
(
  // Clock, reset and device drive
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [SPI_PINS-1:0] spi_port_a_out, spi_port_a_oe, spi_port_b_out, spi_port_b_oe,
  input wire logic [I2C_PINS-1:0] i2c_port_a_out, i2c_port_a_oe,
  // Resolved pin levels
  output logic [SPI_PINS-1:0] spi_port_a_in, spi_port_b_in,
  output logic [I2C_PINS-1:0] i2c_port_a_in
);
  logic [SPI_PINS-1:0] wig_r;
  logic miso_r;
  logic sel;
  // Undriven SPI lines toggle every cycle, so a stale level never passes for data.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wig_r <= 4'h5;
    end else begin
      wig_r <= ~wig_r;
    end
  end
  // The memory answers only while selected, with the inverse of the command bit.
  assign sel = spi_port_a_oe[PIN_CS] && !spi_port_a_out[PIN_CS];
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      miso_r <= 1'b0;
    end else if (sel) begin
      miso_r <= !spi_port_a_out[PIN_MOSI];
    end
  end
  // I2C lines have pull-ups and are only ever pulled low.
  always_comb begin
    spi_port_a_in = (spi_port_a_out & spi_port_a_oe) | (wig_r & ~spi_port_a_oe);
    if (sel && !spi_port_a_oe[PIN_MISO]) begin
      spi_port_a_in[PIN_MISO] = miso_r;
    end
    spi_port_b_in = (spi_port_b_out & spi_port_b_oe) | (wig_r & ~spi_port_b_oe);
    i2c_port_a_in = ~(i2c_port_a_oe & ~i2c_port_a_out);
  end
endmodule : far_pins

/* File: config_pin_share_tb.sv */
// Self-checking bench for the pin sharing top with its far-side model.
`timescale 1ns/1ps
module config_pin_share_tb;
  import pin_share_pkg::*;
  localparam int WAIT_N = 3;
  logic clk_sys = 1'b0, reset = 1'b1, config_reset_n = 1'b1;
  logic config_done_in, config_done_out, config_done_oe, cfg_miso, cfg_running, user_io_live;
  logic cfg_load_done = 1'b0, cfg_sck = 1'b0, cfg_mosi = 1'b0, cfg_cs_n = 1'b1;
  logic spi_a_master = 1'b0, spi_b_master = 1'b0, i2c_a_use = 1'b0;
  logic i2c_scl_low = 1'b1, i2c_sda_low = 1'b0;
  logic [3:0] spi_a_use = 4'h0, spi_b_use = 4'h0, gpio_a_out = 4'ha, gpio_a_oe = 4'hf;
  logic [3:0] gpio_b_out = 4'h5, gpio_b_oe = 4'h3, spi_port_a_in, spi_port_a_out;
  logic [3:0] spi_port_a_oe, spi_port_b_in, spi_port_b_out, spi_port_b_oe;
  logic [3:0] spi_a_pin_level, spi_b_pin_level;
  logic [1:0] gpio_i2c_out = 2'h1, gpio_i2c_oe = 2'h2, i2c_pin_level;
  logic [1:0] i2c_port_a_in, i2c_port_a_out, i2c_port_a_oe;
  logic spi_a_sck_o, spi_a_miso_o, spi_a_mosi_o, spi_a_cs_n_o;
  logic spi_b_sck_o, spi_b_miso_o, spi_b_mosi_o, spi_b_cs_n_o;
  logic [7:0] pat_r = 8'h00;
  int fails = 0;
  int comparisons = 0;
  config_pin_share #(.WAIT_CYCLES(WAIT_N)) u_config_pin_share (.*);
  far_pins u_far_pins (.*);
  // Clock at 200 MHz; controller drive keeps moving so stale values show up.
  always #2.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) pat_r <= pat_r + 8'h01;
  assign {spi_a_sck_o, spi_a_miso_o, spi_a_mosi_o, spi_a_cs_n_o} = pat_r[3:0];
  assign {spi_b_sck_o, spi_b_miso_o, spi_b_mosi_o, spi_b_cs_n_o} = pat_r[7:4];
  assign config_done_in = !(config_done_oe && !config_done_out);
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Configuration drive on port A while user drive is offered and must be ignored.
  task automatic t_config;
    {cfg_cs_n, cfg_mosi, cfg_sck} = 3'b011;
    repeat (6) @(negedge clk_sys);
    chk("a_oe", 4'hd, spi_port_a_oe);
    chk("a_out", 4'h5, spi_port_a_out & 4'hd);
    chk("miso", 4'h0, {3'h0, cfg_miso});
    {cfg_mosi, cfg_sck} = 2'b00;
    repeat (6) @(negedge clk_sys);
    chk("miso", 4'h1, {3'h0, cfg_miso});
    chk("a_out", 4'h0, spi_port_a_out & 4'hd);
    chk("b_oe", 4'h0, spi_port_b_oe | {2'h0, i2c_port_a_oe});
    chk("done", 4'h0, {3'h0, config_done_in});
  endtask : t_config
  // Load a selection, count the release delay, then judge the steering.
  task automatic t_user(input logic ma, mb, iu, input logic [3:0] ua, ub);
    int n;
    logic [3:0] lvl;
    logic [1:0] ilv;
    {spi_a_master, spi_b_master, i2c_a_use, spi_a_use, spi_b_use} = {ma, mb, iu, ua, ub};
    cfg_load_done = 1'b1;
    @(negedge clk_sys);
    cfg_load_done = 1'b0;
    {spi_a_master, spi_b_master, i2c_a_use, spi_a_use} = {!ma, !mb, !iu, ~ua};
    n = 1;
    while (user_io_live !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    // Load edge, WAIT_N edges of wait (done releases on the first), one edge to register user_io_live.
    chk("wait", 4'(WAIT_N + 2), 4'(n));
    @(negedge clk_sys);
    lvl = spi_port_a_in;
    @(negedge clk_sys);
    ilv = iu ? ~{i2c_sda_low, i2c_scl_low} : ~(gpio_i2c_oe & ~gpio_i2c_out);
    chk("a_oe", ({ma, ma, !ma, ma} & ua) | (gpio_a_oe & ~ua), spi_port_a_oe);
    chk("a_ser", {spi_a_cs_n_o, spi_a_mosi_o, spi_a_miso_o, spi_a_sck_o} & ua, spi_port_a_out & ua);
    chk("b_ser", {spi_b_cs_n_o, spi_b_mosi_o, spi_b_miso_o, spi_b_sck_o} & ub, spi_port_b_out & ub);
    chk("b_gpio", gpio_b_out & ~ub, spi_port_b_out & ~ub);
    chk("a_lvl", lvl, spi_a_pin_level);
    chk("i2c_lvl", {2'h0, ilv}, {2'h0, i2c_pin_level});
    chk("a_gpio", gpio_a_out & ~ua, spi_port_a_out & ~ua);
    chk("b_oe", ({mb, mb, !mb, mb} & ub) | (gpio_b_oe & ~ub), spi_port_b_oe);
    chk("i2c_oe", {2'h0, iu ? {i2c_sda_low, i2c_scl_low} : gpio_i2c_oe}, {2'h0, i2c_port_a_oe});
    chk("i2c_out", {2'h0, iu ? 2'h0 : gpio_i2c_out}, {2'h0, i2c_port_a_out});
    chk("done", 4'h1, {3'h0, config_done_in});
  endtask : t_user
  // Configuration reset held low for 200 ns from user mode.
  task automatic t_restart;
    config_reset_n = 1'b0;
    repeat (40) @(negedge clk_sys);
    chk("run", 4'h2, {2'h0, cfg_running, user_io_live});
    config_reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("a_oe", 4'hd, spi_port_a_oe);
    chk("done", 4'h0, {3'h0, config_done_in});
  endtask : t_restart
  task automatic report_and_stop;
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // Watchdog far beyond the fewer than one hundred cycles the sequence needs.
  initial begin
    #20000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    t_config();
    t_user(1'b1, 1'b0, 1'b1, 4'hf, 4'h5);
    t_restart();
    t_user(1'b0, 1'b1, 1'b0, 4'h9, 4'hf);
    report_and_stop();
  end
endmodule : config_pin_share_tb
